// ==== rtl/pdm_ctrl.sv ====
// pdm_ctrl: stop and idle power-down controller with apb registers
// assumes: cpu core pulses op_valid_i with the fetched opcode, takes
// the fetch address and gating outputs, and services wake interrupts
//
// Operation
// - stop instruction halts oscillator, cpu and all peripherals until release
// - registers hold their values while the clock is frozen in stop
// - reset release exits stop, defaults control registers, keeps data
// - reset release clears clock-select bits 4 and 3, slow clock
// - after stabilisation a reset release fetches from address 0100h
// - eight port 0 external interrupts wake the device from stop
// - interrupt wake keeps control registers except the stop arming register
// - stabilisation length programmable; software sets it before stop
// - interrupt wake from stop keeps clock-select bits 4 and 3
// - after interrupt wake, serve interrupt, resume after stop instruction
// - enabled internal interrupts also release stop the same way
// - idle instruction gates cpu clock, peripheral timers keep running
// - port directions stay as they were when idle was entered
// - reset releases idle; with all interrupts masked it is the only exit
// - enabled interrupt releases idle, keeps clock bits, resumes after idle
`timescale 1ns/1ps
`default_nettype none

module pdm_ctrl (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rstn_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // cpu core
   input  wire logic        op_valid_i,
   input  wire logic [7:0]  opcode_i,
   input  wire logic [7:0]  int_req_i,
   input  wire logic [7:0]  port0_wake_interrupts_i,
   input  wire logic [7:0]  port_dir_i,
   // clock and gating
   output logic             osc_en_o,
   output logic             cpu_clk_en_o,
   output logic             periph_clk_en_o,
   output logic [1:0]       clk_sel_o,
   output logic [7:0]       port_dir_o,
   // execution control
   output logic             cpu_start_o,
   output logic             fetch_vec_o,
   output logic [15:0]      fetch_addr_o,
   output logic             wake_irq_o,
   output logic [7:0]       wake_src_o
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      pdm_pkg::pdm_state_t st;
      logic [7:0]          stop_arm;
      logic [7:0]          clk_sel;
      logic [15:0]         stab_len;
      logic [7:0]          int_en;
      logic [7:0]          dir_hold;
      logic                from_reset;
      logic                boot;
      logic                stab_load;
      logic [31:0]         prdata;
      logic                pready;
      logic                pslverr;
      logic                osc_en;
      logic                cpu_en;
      logic                per_en;
      logic                start;
      logic                vec;
      logic                wake_irq;
      logic [7:0]          wake_src;
      logic [15:0]         fetch_addr;
   } pdm_ctrl_t;

   pdm_ctrl_t  s_q;
   pdm_ctrl_t  s_d;
   // data byte lives outside the state struct: it has no reset
   logic [7:0] data_q;
   logic [7:0] data_d;

   logic stab_done;

   // ------------------------------------------------------------
   // stabilisation timer
   // ------------------------------------------------------------
   // busy unused: the state already tracks the interval
   pdm_stab_timer u_stab (
      .mclk_i (mclk_i),
      .rstn_i (rstn_i),
      .load_i (s_q.stab_load),
      .len_i  (s_q.stab_len),
      .busy_o (),
      .done_o (stab_done)
   );

   // ------------------------------------------------------------
   // decoders
   // ------------------------------------------------------------
   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] r);
      addr_hit = (a == r);
   endfunction : addr_hit

   // opcode only counts in the cycle the core marks it executed
   function automatic logic op_is(input logic v, input logic [7:0] o, input logic [7:0] c);
      op_is = v && (o == c);
   endfunction : op_is

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   logic       wr;
   logic       rd;
   logic [7:0] ext_wake;
   logic [7:0] int_wake;
   logic       any_wake;

   // ------------------------------------------------------------
   // wake gating
   // ------------------------------------------------------------
   // one enable bit gates both the pin and the internal request
   for (genvar i = 0; i < 8; i++) begin : g_wake
      assign ext_wake[i] = port0_wake_interrupts_i[i] & s_q.int_en[i];
      assign int_wake[i] = int_req_i[i] & s_q.int_en[i];
   end
   assign any_wake = |(ext_wake | int_wake);

   always_comb begin
      s_d           = s_q;
      s_d.stab_load = 1'b0;
      s_d.start     = 1'b0;
      s_d.vec       = 1'b0;
      s_d.wake_irq  = 1'b0;
      s_d.boot      = 1'b0;
      s_d.pready    = 1'b0;
      s_d.pslverr   = 1'b0;
      wr            = psel_i && penable_i && pwrite_i && !s_q.pready;
      rd            = psel_i && penable_i && !pwrite_i && !s_q.pready;
      data_d        = data_q;

      // ------------------------------------------------------------
      // reset release
      // ------------------------------------------------------------
      // first cycle after reset release: control defaults, stabilise
      if (s_q.boot) begin
         s_d.st        = pdm_pkg::PDM_STAB;
         s_d.stab_load = 1'b1;
      end

      // ------------------------------------------------------------
      // apb access
      // ------------------------------------------------------------
      // apb: one wait state, answer in second access cycle
      if (psel_i && penable_i && !s_q.pready) begin
         s_d.pready = 1'b1;
         if (wr) begin
            unique case (1'b1)
               addr_hit(paddr_i, pdm_pkg::ADDR_STOP_ARM): s_d.stop_arm = pwdata_i[7:0];
               addr_hit(paddr_i, pdm_pkg::ADDR_CLK_SEL):  s_d.clk_sel  = pwdata_i[7:0];
               addr_hit(paddr_i, pdm_pkg::ADDR_STAB):     s_d.stab_len = pwdata_i[15:0];
               addr_hit(paddr_i, pdm_pkg::ADDR_INT_EN):   s_d.int_en   = pwdata_i[7:0];
               addr_hit(paddr_i, pdm_pkg::ADDR_DATA):     data_d       = pwdata_i[7:0];
               // status is read-only: a write is refused with an error
               addr_hit(paddr_i, pdm_pkg::ADDR_STATUS):   s_d.pslverr  = 1'b1;
               default:                                   s_d.pslverr  = 1'b1;
            endcase
         end else if (rd) begin
            s_d.prdata = 32'h0000_0000;
            unique case (1'b1)
               addr_hit(paddr_i, pdm_pkg::ADDR_STOP_ARM): s_d.prdata[7:0]  = s_q.stop_arm;
               addr_hit(paddr_i, pdm_pkg::ADDR_CLK_SEL):  s_d.prdata[7:0]  = s_q.clk_sel;
               addr_hit(paddr_i, pdm_pkg::ADDR_STAB):     s_d.prdata[15:0] = s_q.stab_len;
               addr_hit(paddr_i, pdm_pkg::ADDR_INT_EN):   s_d.prdata[7:0]  = s_q.int_en;
               addr_hit(paddr_i, pdm_pkg::ADDR_DATA):     s_d.prdata[7:0]  = data_q;
               addr_hit(paddr_i, pdm_pkg::ADDR_STATUS): begin
                  s_d.prdata[pdm_pkg::ST_RUN]        = s_q.st == pdm_pkg::PDM_RUN;
                  s_d.prdata[pdm_pkg::ST_STOP]       = s_q.st == pdm_pkg::PDM_STOP;
                  s_d.prdata[pdm_pkg::ST_IDLE]       = s_q.st == pdm_pkg::PDM_IDLE;
                  s_d.prdata[pdm_pkg::ST_STAB]       = s_q.st == pdm_pkg::PDM_STAB;
                  s_d.prdata[pdm_pkg::ST_FROM_RESET] = s_q.from_reset;
               end
               default: s_d.pslverr = 1'b1;
            endcase
         end
      end

      // ------------------------------------------------------------
      // power-down sequencing
      // ------------------------------------------------------------
      unique case (s_q.st)
         pdm_pkg::PDM_RUN: begin
            if (op_is(op_valid_i, opcode_i, pdm_pkg::OPC_STOP)
                && s_q.stop_arm == pdm_pkg::STOP_ARM_VALUE) begin
               // register file simply stops updating from the cpu side
               s_d.st     = pdm_pkg::PDM_STOP;
               s_d.osc_en = 1'b0;
               s_d.cpu_en = 1'b0;
               s_d.per_en = 1'b0;
            end else if (op_is(op_valid_i, opcode_i, pdm_pkg::OPC_IDLE)) begin
               s_d.st       = pdm_pkg::PDM_IDLE;
               s_d.cpu_en   = 1'b0;
               // direction frozen at entry; live pins may move while idle
               s_d.dir_hold = port_dir_i;
            end
         end
         pdm_pkg::PDM_STOP: begin
            // apb writes also blocked in stop: all clocks frozen
            s_d.stop_arm = s_q.stop_arm;
            s_d.clk_sel  = s_q.clk_sel;
            s_d.stab_len = s_q.stab_len;
            s_d.int_en   = s_q.int_en;
            data_d       = data_q;
            if (any_wake) begin
               // only the arming register changes on interrupt wake
               s_d.stop_arm   = pdm_pkg::STOP_ARM_RST;
               s_d.osc_en     = 1'b1;
               s_d.st         = pdm_pkg::PDM_STAB;
               s_d.stab_load  = 1'b1;
               s_d.from_reset = 1'b0;
               s_d.wake_src   = ext_wake | int_wake;
            end
         end
         pdm_pkg::PDM_IDLE: begin
            if (any_wake) begin
               // clock select untouched, cpu resumes after the idle opcode
               s_d.st         = pdm_pkg::PDM_RUN;
               s_d.cpu_en     = 1'b1;
               s_d.start      = 1'b1;
               s_d.wake_irq   = 1'b1;
               s_d.from_reset = 1'b0;
               s_d.wake_src   = ext_wake | int_wake;
            end
         end
         pdm_pkg::PDM_STAB: begin
            if (stab_done) begin
               s_d.st     = pdm_pkg::PDM_RUN;
               s_d.cpu_en = 1'b1;
               s_d.per_en = 1'b1;
               s_d.start  = 1'b1;
               // vector only after a reset; an interrupt wake resumes in place
               s_d.vec    = s_q.from_reset;
               s_d.wake_irq = !s_q.from_reset;
            end
         end
         default: begin
            // illegal code: restart the timer so the machine cannot stall
            s_d.st        = pdm_pkg::PDM_STAB;
            s_d.stab_load = 1'b1;
            s_d.osc_en    = 1'b1;
         end
      endcase
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // async reset puts control fields to defaults; data kept separately
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_q.st         <= pdm_pkg::PDM_STAB;
         s_q.stop_arm   <= pdm_pkg::STOP_ARM_RST;
         s_q.clk_sel    <= pdm_pkg::CLK_SEL_RST;
         s_q.stab_len   <= pdm_pkg::STAB_RST;
         s_q.int_en     <= pdm_pkg::INT_EN_RST;
         s_q.dir_hold   <= '0;
         s_q.from_reset <= 1'b1;
         s_q.boot       <= 1'b1;
         s_q.stab_load  <= 1'b0;
         s_q.prdata     <= '0;
         s_q.pready     <= 1'b0;
         s_q.pslverr    <= 1'b0;
         s_q.osc_en     <= 1'b1;
         s_q.cpu_en     <= 1'b0;
         s_q.per_en     <= 1'b0;
         s_q.start      <= 1'b0;
         s_q.vec        <= 1'b0;
         s_q.wake_irq   <= 1'b0;
         s_q.wake_src   <= '0;
         s_q.fetch_addr <= pdm_pkg::RESET_VECTOR;
      end else begin
         s_q.st         <= s_d.st;
         s_q.stop_arm   <= s_d.stop_arm;
         s_q.clk_sel    <= s_d.clk_sel;
         s_q.stab_len   <= s_d.stab_len;
         s_q.int_en     <= s_d.int_en;
         s_q.dir_hold   <= s_d.dir_hold;
         s_q.from_reset <= s_d.from_reset;
         s_q.boot       <= s_d.boot;
         s_q.stab_load  <= s_d.stab_load;
         s_q.prdata     <= s_d.prdata;
         s_q.pready     <= s_d.pready;
         s_q.pslverr    <= s_d.pslverr;
         s_q.osc_en     <= s_d.osc_en;
         s_q.cpu_en     <= s_d.cpu_en;
         s_q.per_en     <= s_d.per_en;
         s_q.start      <= s_d.start;
         s_q.vec        <= s_d.vec;
         s_q.wake_irq   <= s_d.wake_irq;
         s_q.wake_src   <= s_d.wake_src;
         s_q.fetch_addr <= s_d.fetch_addr;
      end
   end

   // ------------------------------------------------------------
   // data register
   // ------------------------------------------------------------
   // survives reset on purpose: x until software first writes it
   always_ff @(posedge mclk_i) begin
      data_q <= data_d;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // every output is a plain register copy
   assign prdata_o        = s_q.prdata;
   assign pready_o        = s_q.pready;
   assign pslverr_o       = s_q.pslverr;
   assign osc_en_o        = s_q.osc_en;
   assign cpu_clk_en_o    = s_q.cpu_en;
   assign periph_clk_en_o = s_q.per_en;
   assign clk_sel_o       = s_q.clk_sel[pdm_pkg::CLK_SEL_HI:pdm_pkg::CLK_SEL_LO];
   assign port_dir_o      = s_q.dir_hold;
   assign cpu_start_o     = s_q.start;
   assign fetch_vec_o     = s_q.vec;
   assign fetch_addr_o    = s_q.fetch_addr;
   assign wake_irq_o      = s_q.wake_irq;
   assign wake_src_o      = s_q.wake_src;

endmodule : pdm_ctrl

`default_nettype wire

// ==== include/pdm_pkg.sv ====
// pdm_pkg: constants, register map and types of the power-down controller
// assumes: one 20 MHz clock, APB register access, CPU core decodes opcodes
package pdm_pkg;

   // ------------------------------------------------------------
   // opcodes and patterns
   // ------------------------------------------------------------
   localparam logic [7:0] OPC_STOP        = 8'h7F;
   localparam logic [7:0] OPC_IDLE        = 8'h6F;
   localparam logic [7:0] STOP_ARM_VALUE  = 8'hA5;
   localparam logic [15:0] RESET_VECTOR   = 16'h0100;

   // ------------------------------------------------------------
   // register byte addresses (apb, one word each)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_STOP_ARM   = 8'h00;
   localparam logic [7:0] ADDR_CLK_SEL    = 8'h04;
   localparam logic [7:0] ADDR_STAB       = 8'h08;
   localparam logic [7:0] ADDR_INT_EN     = 8'h0C;
   localparam logic [7:0] ADDR_STATUS     = 8'h10;
   localparam logic [7:0] ADDR_DATA       = 8'h14;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int          CLK_SEL_LO     = 3;
   localparam int          CLK_SEL_HI     = 4;
   localparam logic [1:0] CLK_SEL_SLOW    = 2'h0;
   localparam logic [7:0] CLK_SEL_RST     = 8'h00;
   localparam logic [7:0] STOP_ARM_RST    = 8'h00;
   localparam logic [7:0] INT_EN_RST      = 8'h00;
   localparam logic [15:0] STAB_RST       = 16'h0010;
   localparam logic [7:0] DATA_RST        = 8'h00;

   // ------------------------------------------------------------
   // status bit positions
   // ------------------------------------------------------------
   localparam int          ST_RUN         = 0;
   localparam int          ST_STOP        = 1;
   localparam int          ST_IDLE        = 2;
   localparam int          ST_STAB        = 3;
   localparam int          ST_FROM_RESET  = 4;

   typedef enum logic [3:0] {
      PDM_RUN  = 4'h1,
      PDM_STOP = 4'h2,
      PDM_IDLE = 4'h4,
      PDM_STAB = 4'h8
   } pdm_state_t;

endpackage : pdm_pkg

// ==== rtl/pdm_stab_timer.sv ====
// pdm_stab_timer: oscillation stabilisation down-counter
// assumes: load pulse starts a run of len cycles; done pulses once at end
`timescale 1ns/1ps
`default_nettype none

module pdm_stab_timer (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rstn_i,
   // control
   input  wire logic        load_i,
   input  wire logic [15:0] len_i,
   // status
   output logic             busy_o,
   output logic             done_o
);

   typedef struct packed {
      logic [15:0] cnt;
      logic        busy;
      logic        done;
   } pdm_tmr_t;

   pdm_tmr_t s_q;
   pdm_tmr_t s_d;

   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      if (load_i) begin
         // zero length still takes one cycle
         s_d.cnt  = (len_i == 16'h0000) ? 16'h0001 : len_i;
         s_d.busy = 1'b1;
      end else if (s_q.busy) begin
         s_d.cnt = s_q.cnt - 16'h0001;
         if (s_q.cnt == 16'h0001) begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign busy_o = s_q.busy;
   assign done_o = s_q.done;

endmodule : pdm_stab_timer

`default_nettype wire

// ==== sim/pdm_cpu_model.sv ====
// pdm_cpu_model: behavioural cpu core issuing power-down opcodes
// assumes: caller arms stop through apb before asking for a stop op
`timescale 1ns/1ps
`default_nettype none
module pdm_cpu_model (
   // clock and reset
   input  wire logic       mclk_i,
   input  wire logic       rstn_i,
   // from controller
   input  wire logic       cpu_start_i,
   input  wire logic       wake_irq_i,
   // to controller
   output var  logic       op_valid_o,
   output var  logic [7:0] opcode_o
);
   int n_served = 0;
   initial begin
      op_valid_o = 1'b0;
      opcode_o   = 8'h00;
   end
   // counts interrupt wakes served: a start pulse together with wake_irq out of reset
   always @(posedge mclk_i) begin
      if (rstn_i && cpu_start_i && wake_irq_i) begin
         n_served++;
      end
   end
   // one-cycle op pulse; stop only after the arming write
   task automatic exec(input logic [7:0] op);
      @(posedge mclk_i);
      op_valid_o <= 1'b1;
      opcode_o   <= op;
      @(posedge mclk_i);
      op_valid_o <= 1'b0;
      opcode_o   <= ~op;
   endtask : exec
endmodule : pdm_cpu_model
`default_nettype wire

// ==== sim/pdm_ctrl_props.sv ====
// pdm_ctrl_props: concurrent checks on the power-down controller ports
// assumes: bound to pdm_ctrl; stabilisation length stays below 990
`timescale 1ns/1ps
`default_nettype none
module pdm_ctrl_props (
   input wire logic        mclk_i,
   input wire logic        rstn_i,
   input wire logic        op_valid_i,
   input wire logic [7:0]  opcode_i,
   input wire logic [7:0]  port_dir_i,
   input wire logic        osc_en_o,
   input wire logic        cpu_clk_en_o,
   input wire logic        periph_clk_en_o,
   input wire logic [1:0]  clk_sel_o,
   input wire logic [7:0]  port_dir_o,
   input wire logic        cpu_start_o,
   input wire logic        fetch_vec_o,
   input wire logic [15:0] fetch_addr_o,
   input wire logic        wake_irq_o,
   input wire logic [7:0]  wake_src_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   sequence stab_wait;
      !cpu_start_o ##[1:1000] (cpu_start_o && wake_irq_o);
   endsequence
   sequence idle_hold;
      !cpu_clk_en_o && periph_clk_en_o;
   endsequence
   stop_halt_a: assert property ($fell(osc_en_o) |->
      $past(op_valid_i && opcode_i == pdm_pkg::OPC_STOP)) else $error("osc stopped without stop");
   all_off_a: assert property (!osc_en_o |-> !cpu_clk_en_o && !periph_clk_en_o)
      else $error("clock running in stop");
   idle_gate_a: assert property (op_valid_i && opcode_i == pdm_pkg::OPC_IDLE && cpu_clk_en_o
      |=> idle_hold and (osc_en_o && port_dir_o == $past(port_dir_i))) else $error("idle entry");
   idle_dir_a: assert property (idle_hold ##1 idle_hold |-> $stable(port_dir_o))
      else $error("port direction moved in idle");
   stop_sel_a: assert property (!osc_en_o ##1 !osc_en_o |-> $stable(clk_sel_o))
      else $error("clock select moved in stop");
   wake_sel_a: assert property ($rose(osc_en_o) |-> $stable(clk_sel_o) ##0 stab_wait)
      else $error("stop wake sequence");
   rst_sel_a: assert property ($rose(rstn_i) |-> clk_sel_o == pdm_pkg::CLK_SEL_SLOW && osc_en_o)
      else $error("reset clock select");
   boot_run_a: assert property ($rose(rstn_i) |-> ##[1:70] (cpu_start_o && fetch_vec_o))
      else $error("no boot start");
   vec_addr_a: assert property (fetch_vec_o |-> cpu_start_o && !wake_irq_o
      && fetch_addr_o == pdm_pkg::RESET_VECTOR) else $error("boot vector");
   irq_src_a: assert property (wake_irq_o |-> cpu_start_o && !fetch_vec_o && wake_src_o != 8'h00)
      else $error("wake without source");
   run_on_a: assert property (cpu_start_o |-> ##[0:1] (cpu_clk_en_o && periph_clk_en_o))
      else $error("clock not back after start");
endmodule : pdm_ctrl_props
bind pdm_ctrl pdm_ctrl_props pdm_ctrl_props_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
   .op_valid_i(op_valid_i), .opcode_i(opcode_i), .port_dir_i(port_dir_i), .osc_en_o(osc_en_o),
   .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o), .clk_sel_o(clk_sel_o),
   .port_dir_o(port_dir_o), .cpu_start_o(cpu_start_o), .fetch_vec_o(fetch_vec_o),
   .fetch_addr_o(fetch_addr_o), .wake_irq_o(wake_irq_o), .wake_src_o(wake_src_o));
`default_nettype wire

// ==== sim/test_power_down_mode_control.sv ====
// test_power_down_mode_control: apb and opcode driven bench of pdm_ctrl
// assumes: pdm_cpu_model issues opcodes; outputs sampled before edge updates
`timescale 1ns/1ps
`default_nettype none
module test_power_down_mode_control;
   logic        mclk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
   logic [7:0]  paddr = 8'h00, ireq = 8'h00, p0 = 8'h00, pdir = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, opv, osc, cpu_en, per_en, start, fvec, wirq;
   logic [7:0]  opc, pdir_o, wsrc;
   logic [1:0]  csel;
   logic [15:0] faddr;
   int          n_mismatch = 0, checks_done = 0, n, n5, n12;
   always #25 mclk_i = ~mclk_i;
   pdm_ctrl pdm_ctrl_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .op_valid_i(opv), .opcode_i(opc), .int_req_i(ireq),
      .port0_wake_interrupts_i(p0), .port_dir_i(pdir), .osc_en_o(osc), .cpu_clk_en_o(cpu_en),
      .periph_clk_en_o(per_en), .clk_sel_o(csel), .port_dir_o(pdir_o), .cpu_start_o(start),
      .fetch_vec_o(fvec), .fetch_addr_o(faddr), .wake_irq_o(wirq), .wake_src_o(wsrc));
   pdm_cpu_model pdm_cpu_model_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .cpu_start_i(start),
      .wake_irq_i(wirq), .op_valid_o(opv), .opcode_o(opc));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // apb master; reads here see pre-edge values, i.e. what the edge samples
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int k = 0;
      @(posedge mclk_i);
      psel   <= 1'b1;
      pwr    <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge mclk_i);
      pen <= 1'b1;
      do @(posedge mclk_i); while (pready !== 1'b1 && k++ < 20);
      chk("pready", 1, pready);
      rd  = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask : apb
   task automatic rchk(input string w, input logic [7:0] a, input logic [15:0] e);
      apb(1'b0, a, 32'h0);
      chk(w, {16'h0, e}, {16'h0, rd[15:0]});
   endtask : rchk
   task automatic wait_start(output int c);
      c = 0;
      do begin
         @(posedge mclk_i);
         c++;
      end while (start !== 1'b1 && c < 1200);
      chk("start", 1, start);
   endtask : wait_start
   task automatic stop_wake(input logic ext, input int b, output int c);
      apb(1'b1, pdm_pkg::ADDR_STOP_ARM, 32'hA5);
      pdm_cpu_model_inst.exec(pdm_pkg::OPC_STOP);
      @(negedge mclk_i);
      chk("osc_en", 0, osc);
      chk("periph_en", 0, per_en);
      apb(1'b1, pdm_pkg::ADDR_DATA, 32'hEE);
      @(posedge mclk_i);
      if (ext) p0[b] <= 1'b1;
      else ireq[b] <= 1'b1;
      wait_start(c);
      chk("wake_irq", 1, wirq);
      chk("wake_src", 1 << b, wsrc);
      p0   <= 8'h00;
      ireq <= 8'h00;
      chk("clk_sel", 2'b10, csel);
      rchk("arming", pdm_pkg::ADDR_STOP_ARM, 16'h0);
      rchk("clk reg", pdm_pkg::ADDR_CLK_SEL, 16'h10);
      rchk("data", pdm_pkg::ADDR_DATA, 16'h5A);
   endtask : stop_wake
   task automatic pulse_reset;
      @(posedge mclk_i);
      rstn_i <= 1'b0;
      @(posedge mclk_i);
      rstn_i <= 1'b1;
      @(negedge mclk_i);
      chk("osc after reset", 1, osc);
      chk("clk_sel after reset", 0, csel);
      wait_start(n);
      chk("fetch_vec", 1, fvec);
      chk("fetch addr", 16'h0100, faddr);
   endtask : pulse_reset
   task automatic test_done;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (20000) @(posedge mclk_i);
      n_mismatch++;
      test_done();
   end
   initial begin
      repeat (20) @(posedge mclk_i);
      rstn_i <= 1'b1;
      wait_start(n);
      chk("boot vec", 1, fvec);
      chk("boot addr", 16'h0100, faddr);
      rchk("stab default", pdm_pkg::ADDR_STAB, 16'h0010);
      rchk("int_en default", pdm_pkg::ADDR_INT_EN, 16'h0);
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped err", 1, err);
      apb(1'b1, pdm_pkg::ADDR_STATUS, 32'h0);
      chk("status write err", 1, err);
      pdm_cpu_model_inst.exec(pdm_pkg::OPC_STOP);
      repeat (2) @(negedge mclk_i);
      chk("unarmed stop", 1, osc);
      apb(1'b1, pdm_pkg::ADDR_CLK_SEL, 32'h10);
      apb(1'b1, pdm_pkg::ADDR_DATA, 32'h5A);
      apb(1'b1, pdm_pkg::ADDR_INT_EN, 32'hFF);
      apb(1'b1, pdm_pkg::ADDR_STAB, 32'h5);
      for (int b = 0; b < 8; b++) begin
         stop_wake(1'b1, b, n);
         if (b == 0) n5 = n;
      end
      stop_wake(1'b0, 3, n);
      apb(1'b1, pdm_pkg::ADDR_STAB, 32'hC);
      stop_wake(1'b1, 0, n12);
      chk("stab delta", 7, n12 - n5);
      chk("served", 10, pdm_cpu_model_inst.n_served);
      // idle: bit 0 masked must not wake, bit 1 enabled must
      apb(1'b1, pdm_pkg::ADDR_INT_EN, 32'h2);
      pdir <= 8'h3C;
      pdm_cpu_model_inst.exec(pdm_pkg::OPC_IDLE);
      pdir    <= 8'hC3;
      ireq[0] <= 1'b1;
      repeat (6) @(negedge mclk_i);
      chk("idle cpu_en", 0, cpu_en);
      chk("idle periph", 1, per_en);
      chk("idle port dir", 8'h3C, pdir_o);
      @(posedge mclk_i);
      ireq[1] <= 1'b1;
      wait_start(n);
      chk("idle wake irq", 1, wirq);
      chk("idle clk_sel", 2'b10, csel);
      ireq <= 8'h00;
      pdm_cpu_model_inst.exec(pdm_pkg::OPC_IDLE);
      pulse_reset();
      rchk("clk reg idle reset", pdm_pkg::ADDR_CLK_SEL, 16'h0);
      rchk("data idle reset", pdm_pkg::ADDR_DATA, 16'h5A);
      apb(1'b1, pdm_pkg::ADDR_CLK_SEL, 32'h18);
      apb(1'b1, pdm_pkg::ADDR_STOP_ARM, 32'hA5);
      pdm_cpu_model_inst.exec(pdm_pkg::OPC_STOP);
      pulse_reset();
      rchk("data stop reset", pdm_pkg::ADDR_DATA, 16'h5A);
      rchk("arming stop reset", pdm_pkg::ADDR_STOP_ARM, 16'h0);
      test_done();
   end
endmodule : test_power_down_mode_control
`default_nettype wire
